// ==== inc/raw_link_framer_defs.svh ====
// raw link record framer constants
// included by the framer package and the framer design file
`ifndef RAW_LINK_FRAMER_DEFS_SVH
`define RAW_LINK_FRAMER_DEFS_SVH
`define REC_HDR_BYTES      16'h0010
`define EXT_HDR_BYTES      16'h0008
`define REC_TYPE_RAW_LINK  7'h18
`define EXT_TYPE_RAW_LINK  7'h05
`define REC_HDR_WORDS      2'h2
`define FIFO_DEPTH_DEF     8
`endif

// ==== inc/raw_link_framer_pkg.sv ====
// types shared by the raw link record framer
// assumes the constants header is on the include path
`include "raw_link_framer_defs.svh"
package raw_link_framer_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR0 = 4'b0010,
        ST_HDR1 = 4'b0100,
        ST_EXT  = 4'b1000
    } fr_state_t;
endpackage : raw_link_framer_pkg

// ==== design/sync_fifo.sv ====
// synchronous fifo with registered read data
// single clock; source and sink use valid/ready
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0]      wp;
        logic [AW:0]      rp;
        logic             ov;
        logic [WIDTH-1:0] od;
    } fifo_st_t;
    fifo_st_t         s_r;
    fifo_st_t         s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      cnt;
    logic             wr;
    logic             rd;

    assign cnt       = s_r.wp - s_r.rp;
    assign in_ready  = (cnt != (AW+1)'(DEPTH));
    assign wr        = in_valid && in_ready;
    // output register refills when empty or consumed
    assign rd        = (cnt != '0) && (!s_r.ov || out_ready);
    assign out_data  = s_r.od;
    assign out_valid = s_r.ov;

    always_comb begin
        s_nxt = s_r;
        if (wr) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
            s_nxt.od = mem[s_r.rp[AW-1:0]];
            s_nxt.ov = 1'b1;
        end else if (out_ready) begin
            s_nxt.ov = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (wr) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : sync_fifo
`default_nettype wire

// ==== design/raw_link_record_framer.sv ====
// raw link capture record framer: header words, extension header, payload
// payload words arrive from a same-clock receive framer; output to capture buffer
// Overview of operation
// - type bit 7 set when extensions follow
// - record type low bits equal 24
// - payload equals length minus headers
// - each extension header is eight bytes
// - extension bit 63 flags another header
// - extension type field holds 0x05
// - bit 55 marks continued fragment
// - sequence number in bits 31:16, from zero
// - rate byte copied from link control
// - framing byte copied from link control
// - raw records always carry extension header
`timescale 1ns/1ps
`default_nettype none
`include "raw_link_framer_defs.svh"
module raw_link_record_framer
    import raw_link_framer_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  line_rate,
    input  wire logic [7:0]  framing_type,
    input  wire logic        rec_start,
    input  wire logic        rec_continued,
    input  wire logic [15:0] rec_payload_bytes,
    output logic             rec_start_ready,
    input  wire logic [63:0] pay_data,
    input  wire logic        pay_valid,
    input  wire logic        pay_last,
    output logic             pay_ready,
    output logic      [63:0] out_data,
    output logic             out_valid,
    output logic             out_last,
    input  wire logic        out_ready
);
    typedef struct packed {
        fr_state_t        st;
        logic      [15:0] seq;
        logic      [15:0] rlen;
        logic             frag;
        logic      [7:0]  rate;
        logic      [7:0]  ftype;
    } fr_st_t;

    fr_st_t      s_r;
    fr_st_t      s_nxt;
    logic [1:0]  rst_sync_r;
    logic        rst_int_n;
    logic [64:0] f_in;
    logic        f_valid;
    logic        f_ready;
    logic [64:0] f_out;

    function automatic logic [7:0] rec_type_byte(input logic ext_present);
        return {ext_present, `REC_TYPE_RAW_LINK};
    endfunction : rec_type_byte

    function automatic logic [63:0] ext_word(input logic more, input logic frag,
                                             input logic [15:0] seq,
                                             input logic [7:0] rate,
                                             input logic [7:0] ftype);
        // reserved 54:32 held at zero
        return {more, `EXT_TYPE_RAW_LINK, frag, 23'h000000, seq, rate, ftype};
    endfunction : ext_word

    // reset synchroniser kept apart: it runs on the raw reset, the state on the copy
    assign rst_int_n = rst_sync_r[1];

    always_comb begin
        s_nxt           = s_r;
        rec_start_ready = (s_r.st == ST_IDLE);
        pay_ready      = 1'b0;
        f_valid        = 1'b0;
        f_in           = '0;
        unique case (s_r.st)
            ST_IDLE: begin
                if (rec_start) begin
                    // length = header + one extension + payload
                    s_nxt.rlen  = rec_payload_bytes + `REC_HDR_BYTES + `EXT_HDR_BYTES;
                    s_nxt.frag  = rec_continued;
                    s_nxt.rate  = line_rate;
                    s_nxt.ftype = framing_type;
                    s_nxt.st    = ST_HDR0;
                end
            end
            ST_HDR0: begin
                // word 0: timestamp left zero; word 1 carries type and length
                f_valid = 1'b1;
                f_in    = {1'b0, 64'h0};
                if (f_ready) begin
                    s_nxt.st = ST_HDR1;
                end
            end
            ST_HDR1: begin
                f_valid = 1'b1;
                f_in    = {1'b0, rec_type_byte(1'b1), 24'h000000, s_r.rlen, 16'h0000};
                if (f_ready) begin
                    s_nxt.st = ST_EXT;
                end
            end
            ST_EXT: begin
                f_valid = 1'b1;
                f_in    = {1'b0, ext_word(1'b0, s_r.frag, s_r.seq, s_r.rate, s_r.ftype)};
                if (f_ready) begin
                    s_nxt.seq = s_r.seq + 16'h0001;
                    s_nxt.st  = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        // payload passes once headers are queued
        if (s_r.st == ST_IDLE && !rec_start) begin
            pay_ready = f_ready;
            f_valid   = pay_valid;
            f_in      = {pay_last, pay_data};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_r.st    <= ST_IDLE;
            s_r.seq   <= 16'h0000;
            s_r.rlen  <= 16'h0000;
            s_r.frag  <= 1'b0;
            s_r.rate  <= 8'h00;
            s_r.ftype <= 8'h00;
        end else begin
            s_r.st    <= s_nxt.st;
            s_r.seq   <= s_nxt.seq;
            s_r.rlen  <= s_nxt.rlen;
            s_r.frag  <= s_nxt.frag;
            s_r.rate  <= s_nxt.rate;
            s_r.ftype <= s_nxt.ftype;
        end
    end

    sync_fifo #(
        .WIDTH (65),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_int_n),
        .in_data   (f_in),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (f_out),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    assign out_data = f_out[63:0];
    assign out_last = f_out[64];

    a_ext_after_hdr: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_HDR1 && f_ready) |=> (s_r.st == ST_EXT))
        else $error("extension word must follow header");
    a_type_flag: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_HDR1) |-> (f_in[63:56] == 8'h98))
        else $error("record type byte wrong");
    a_type_code: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_HDR1) |-> (f_in[62:56] == 7'h18))
        else $error("record type code not 24");
    a_len_sum: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_IDLE && rec_start) |=>
        (s_r.rlen == $past(rec_payload_bytes) + 16'h0018))
        else $error("record length mismatch");
    a_ext_last: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_EXT) |-> !f_in[63])
        else $error("single extension must not flag more");
    a_ext_code: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_EXT) |-> (f_in[62:56] == 7'h05 && f_in[54:32] == 23'h0))
        else $error("extension type or reserved bits wrong");
    a_frag_bit: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_EXT) |-> (f_in[55] == s_r.frag))
        else $error("fragment bit mismatch");
    a_seq_step: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_EXT && f_ready) |=> (s_r.seq == $past(s_r.seq) + 16'h0001))
        else $error("sequence did not step by one");
    a_rate_copy: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_IDLE && rec_start) |=> (s_r.rate == $past(line_rate)))
        else $error("rate not captured");
    a_ftype_copy: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st == ST_IDLE && rec_start) |=> (s_r.ftype == $past(framing_type)))
        else $error("framing type not captured");

    // start handshake, then the first header word
    sequence s_start_taken;
        (s_r.st == ST_IDLE) && rec_start;
    endsequence
    sequence s_hdr_begin;
        (s_r.st == ST_HDR0);
    endsequence
    a_start_hdr: assert property (@(posedge clk) disable iff (!rst_int_n)
        s_start_taken |=> s_hdr_begin)
        else $error("record start did not begin header");
    a_pay_blocked: assert property (@(posedge clk) disable iff (!rst_int_n)
        (s_r.st != ST_IDLE || rec_start) |-> !pay_ready)
        else $error("payload taken during header");
endmodule : raw_link_record_framer
`default_nettype wire

// ==== testbench/capture_sink.sv ====
// host capture buffer model: stores every accepted record word
// assumes the framer output handshake runs on the same clock
`timescale 1ns/1ps
`default_nettype none
module capture_sink (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic [63:0] out_data,
    input  wire logic        out_valid,
    input  wire logic        out_last,
    output logic             out_ready
);
    logic [63:0] mem [0:255];
    logic        lst [0:255];
    int          n = 0;
    assign out_ready = !stall;
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            mem[n] <= out_data;
            lst[n] <= out_last;
            n      <= n + 1;
        end
    end
endmodule : capture_sink
`default_nettype wire

// ==== testbench/test_raw_link_record_framer.sv ====
// bench for the raw link record framer: sends records, checks stored words
// assumes the capture sink model and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_raw_link_record_framer;
    logic        clk = 1'b0, rst_n = 1'b0, rec_start = 1'b0, rec_continued = 1'b0;
    logic        pay_valid = 1'b0, pay_last = 1'b0, stall = 1'b0;
    logic [7:0]  line_rate = 8'h00, framing_type = 8'h00;
    logic [15:0] rec_payload_bytes = 16'h0000, seq = 16'h0000;
    logic [63:0] pay_data = 64'h0, out_data;
    logic        rec_start_ready, pay_ready, out_valid, out_last, out_ready;
    int          error_cnt = 0, checks = 0, cyc = 0;
    raw_link_record_framer i_dut (.clk(clk), .rst_n(rst_n), .line_rate(line_rate),
        .framing_type(framing_type), .rec_start(rec_start), .rec_continued(rec_continued),
        .rec_payload_bytes(rec_payload_bytes), .rec_start_ready(rec_start_ready),
        .pay_data(pay_data), .pay_valid(pay_valid), .pay_last(pay_last),
        .pay_ready(pay_ready), .out_data(out_data), .out_valid(out_valid),
        .out_last(out_last), .out_ready(out_ready));
    capture_sink i_sink (.clk(clk), .stall(stall), .out_data(out_data),
        .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            close_out();
        end
    end
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic [63:0] pword(input int k);
        return {8'ha5, seq[7:0], 40'h0, 8'(k)};
    endfunction : pword
    task automatic send(input logic [7:0] r, input logic [7:0] f, input logic c, input int nw);
        @(posedge clk);
        rec_start <= 1'b1;
        line_rate <= r;
        framing_type <= f;
        rec_continued <= c;
        rec_payload_bytes <= 16'(nw * 8);
        do @(posedge clk); while (rec_start_ready !== 1'b1);
        rec_start <= 1'b0;
        @(posedge clk);
        cmp(64'(rec_start_ready), 64'h0);
        for (int k = 0; k < nw; k++) begin
            pay_data <= pword(k);
            pay_valid <= 1'b1;
            pay_last <= (k == nw - 1);
            do @(posedge clk); while (pay_ready !== 1'b1);
        end
        pay_valid <= 1'b0;
    endtask : send
    task automatic check_rec(input int b, input logic [7:0] r, input logic [7:0] f,
                             input logic c, input int nw);
        int t;
        t = 0;
        while (i_sink.n < b + 3 + nw && t < 200) begin
            @(posedge clk);
            t++;
        end
        cmp(64'(i_sink.n), 64'(b + 3 + nw));
        cmp(i_sink.mem[b], 64'h0);
        cmp(64'(i_sink.lst[b + 2]), 64'h0);
        cmp(i_sink.mem[b + 1][63:56], 64'h98);
        cmp(i_sink.mem[b + 1][31:16], 64'(nw * 8 + 24));
        cmp(i_sink.mem[b + 2], {1'b0, 7'h05, c, 23'h0, seq, r, f});
        for (int k = 0; k < nw; k++) cmp(i_sink.mem[b + 3 + k], pword(k));
        cmp(64'(i_sink.lst[b + 2 + nw]), 64'h1);
        seq = seq + 16'h0001;
    endtask : check_rec
    task automatic test_rates;
        int b;
        for (int r = 1; r <= 4; r++) begin
            // record start index taken before header words can arrive
            b = i_sink.n;
            send(8'(r), 8'(r % 2), r[0], r);
            check_rec(b, 8'(r), 8'(r % 2), r[0], r);
        end
        $display("test_rates done");
    endtask : test_rates
    task automatic test_stall;
        int b;
        b = i_sink.n;
        stall <= 1'b1;
        fork
            send(8'h02, 8'h01, 1'b1, 9);
            begin
                repeat (40) @(posedge clk);
                cmp(64'(i_sink.n), 64'(b));
                cmp(64'(pay_ready), 64'h0);
                stall <= 1'b0;
            end
        join
        check_rec(b, 8'h02, 8'h01, 1'b1, 9);
        $display("test_stall done");
    endtask : test_stall
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_rates();
        test_stall();
        close_out();
    end
endmodule : test_raw_link_record_framer
`default_nettype wire
